// File: dca_column_access.v
// DDR2 device column access: burst read/write, data mask and precharge.
// Assumes a controller on the pins and an AHB-Lite master for registers.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "dca_consts.vh"
module dca_column_access #(
  parameter COL_W = 10,
  parameter PIPE_D = 16
) (
  input wire SYS_CLK,
  input wire RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire CK,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire [13:0] ADDR,
  input wire [2:0] BA,
  input wire [1:0] DM,
  input wire [15:0] DQ_IN,
  input wire DQS_IN,
  output reg [15:0] DQ_OUT,
  output reg DQ_OE,
  output reg DQS_OUT,
  output reg DQS_OE
);
  localparam AW = COL_W + 3;

  // Beat column within the burst segment, nibble based for sequential
  function [2:0] beat_col;
    input [2:0] start;
    input [2:0] beat;
    input bl8;
    input inter;
    reg [2:0] s;
    begin
      if (inter) begin
        s = start ^ beat;
      end else begin
        s = {start[2] ^ beat[2], start[1:0] + beat[1:0]};
      end
      if (!bl8) begin
        s[2] = start[2];
      end
      beat_col = s;
    end
  endfunction

  function [7:0] bank_hot;
    input [2:0] b;
    begin
      bank_hot = 8'h01 << b;
    end
  endfunction

  // Pin synchronisers; command pins settle long before a CK edge
  reg [21:0] cs1_q;
  reg [21:0] cs2_q;
  reg ck3_q;
  reg [18:0] ds1_q;
  reg [18:0] ds2_q;
  reg dqs3_q;
  always @(posedge SYS_CLK) begin
    if (RST) begin
      cs1_q <= 22'h3FFFFF;
      cs2_q <= 22'h3FFFFF;
      ck3_q <= 1'b1;
      ds1_q <= 19'h00000;
      ds2_q <= 19'h00000;
      dqs3_q <= 1'b0;
    end else begin
      cs1_q <= {CK, CS_N, RAS_N, CAS_N, WE_N, ADDR, BA};
      cs2_q <= cs1_q;
      ck3_q <= cs2_q[21];
      ds1_q <= {DQS_IN, DM, DQ_IN};
      ds2_q <= ds1_q;
      dqs3_q <= ds2_q[18];
    end
  end

  wire ck_s = cs2_q[21];
  wire cs_n_s = cs2_q[20];
  wire ras_n_s = cs2_q[19];
  wire cas_n_s = cs2_q[18];
  wire we_n_s = cs2_q[17];
  wire [13:0] addr_s = cs2_q[16:3];
  wire [2:0] ba_s = cs2_q[2:0];
  wire ck_rise = ck_s & ~ck3_q;
  wire ck_fall = ~ck_s & ck3_q;
  wire ck_edge = ck_rise | ck_fall;
  wire dqs_s = ds2_q[18];
  wire [1:0] dm_s = ds2_q[17:16];
  wire [15:0] dq_s = ds2_q[15:0];
  wire dqs_rise = dqs_s & ~dqs3_q;
  wire dqs_edge = dqs_s ^ dqs3_q;

  wire cmd_rd = ck_rise & ~cs_n_s & ras_n_s & ~cas_n_s & we_n_s;
  wire cmd_wr = ck_rise & ~cs_n_s & ras_n_s & ~cas_n_s & ~we_n_s;
  wire cmd_pre = ck_rise & ~cs_n_s & ~ras_n_s & cas_n_s & ~we_n_s;

  // Registers
  reg [31:0] mode_q;
  reg [31:0] ext_q;
  reg [7:0] bank_q;
  reg err_q;
  wire [2:0] cl = mode_q[`DCA_CL_MSB:`DCA_CL_LSB];
  wire [2:0] al = ext_q[`DCA_AL_MSB:`DCA_AL_LSB];
  wire bl8 = mode_q[`DCA_BL_MSB:`DCA_BL_LSB] == `DCA_BL8_CODE;
  wire inter = mode_q[`DCA_BT_BIT];
  wire [2:0] last_beat = bl8 ? `DCA_LAST_BL8 : `DCA_LAST_BL4;
  wire [3:0] rl = {1'b0, al} + {1'b0, cl};
  wire [3:0] i_rd = rl - `DCA_RD_TAP;
  wire [3:0] i_pre = rl - `DCA_PRE_TAP;
  wire [3:0] i_warm = rl - `DCA_WARM_TAP;

  // Command delay line, one stage per CK cycle
  reg pv_rd [0:PIPE_D-1];
  reg pv_wr [0:PIPE_D-1];
  reg [2:0] p_bank [0:PIPE_D-1];
  reg [COL_W-1:0] p_col [0:PIPE_D-1];
  integer k;
  always @(posedge SYS_CLK) begin
    if (RST) begin
      for (k = 0; k < PIPE_D; k = k + 1) begin
        pv_rd[k] <= 1'b0;
        pv_wr[k] <= 1'b0;
        p_bank[k] <= 3'h0;
        p_col[k] <= {COL_W{1'b0}};
      end
    end else if (ck_rise) begin
      pv_rd[0] <= cmd_rd;
      pv_wr[0] <= cmd_wr;
      p_bank[0] <= ba_s;
      p_col[0] <= addr_s[COL_W-1:0];
      for (k = 1; k < PIPE_D; k = k + 1) begin
        pv_rd[k] <= pv_rd[k-1];
        pv_wr[k] <= pv_wr[k-1];
        p_bank[k] <= p_bank[k-1];
        p_col[k] <= p_col[k-1];
      end
    end
  end

  // Read engine; a new start replaces any running burst
  reg rd_act_q;
  reg [2:0] rd_cnt_q;
  reg [2:0] rd_bank_q;
  reg [COL_W-1:0] rd_col_q;
  reg iss_q;
  reg phase_q;
  reg pre_q;
  reg off_q;
  wire rd_start = ck_rise & pv_rd[i_rd];
  wire rd_issue = ck_edge & (rd_start | rd_act_q);
  wire [2:0] rd_sbank = rd_start ? p_bank[i_rd] : rd_bank_q;
  wire [COL_W-1:0] rd_scol = rd_start ? p_col[i_rd] : rd_col_q;
  wire [2:0] rd_beat = rd_start ? 3'h0 : rd_cnt_q;
  wire [AW-1:0] rd_addr = {rd_sbank, rd_scol[COL_W-1:3],
    beat_col(rd_scol[2:0], rd_beat, bl8, inter)};
  wire [15:0] mem_rdata;

  always @(posedge SYS_CLK) begin
    if (RST) begin
      rd_act_q <= 1'b0;
      rd_cnt_q <= 3'h0;
      rd_bank_q <= 3'h0;
      rd_col_q <= {COL_W{1'b0}};
    end else if (rd_start) begin
      rd_act_q <= 1'b1;
      rd_cnt_q <= 3'h1;
      rd_bank_q <= p_bank[i_rd];
      rd_col_q <= p_col[i_rd];
    end else if (ck_edge && rd_act_q) begin
      rd_cnt_q <= rd_cnt_q + 3'h1;
      if (rd_cnt_q == last_beat) begin
        rd_act_q <= 1'b0;
      end
    end
  end

  // Pin stage lags the sampled CK edge by one clock for memory access
  always @(posedge SYS_CLK) begin
    if (RST) begin
      iss_q <= 1'b0;
      phase_q <= 1'b0;
      pre_q <= 1'b0;
      off_q <= 1'b0;
      DQ_OUT <= 16'h0000;
      DQ_OE <= 1'b0;
      DQS_OUT <= 1'b0;
      DQS_OE <= 1'b0;
    end else begin
      iss_q <= rd_issue;
      phase_q <= ck_rise;
      pre_q <= ck_rise & ~rd_issue & pv_rd[i_pre];
      off_q <= ck_rise & ~rd_issue & ~pv_rd[i_pre];
      if (iss_q) begin
        DQ_OUT <= mem_rdata;
        DQ_OE <= 1'b1;
        DQS_OUT <= phase_q;
        DQS_OE <= 1'b1;
      end else if (pre_q) begin
        DQ_OE <= 1'b0;
        DQS_OUT <= 1'b0;
        DQS_OE <= 1'b1;
      end else if (off_q) begin
        DQ_OE <= 1'b0;
        DQS_OUT <= 1'b0;
        DQS_OE <= 1'b0;
      end
    end
  end

  // Write engine; armed mid-preamble so the first rising strobe is caught
  reg wp_q;
  reg [2:0] wp_bank_q;
  reg [COL_W-1:0] wp_col_q;
  reg wr_act_q;
  reg [2:0] wr_cnt_q;
  reg [2:0] wr_bank_q;
  reg [COL_W-1:0] wr_col_q;
  wire wr_start = dqs_rise & wp_q;
  wire wr_take = dqs_edge & (wr_start | wr_act_q);
  wire [2:0] wr_sbank = wr_start ? wp_bank_q : wr_bank_q;
  wire [COL_W-1:0] wr_scol = wr_start ? wp_col_q : wr_col_q;
  wire [2:0] wr_beat = wr_start ? 3'h0 : wr_cnt_q;
  wire [AW-1:0] wr_addr = {wr_sbank, wr_scol[COL_W-1:3],
    beat_col(wr_scol[2:0], wr_beat, bl8, inter)};

  always @(posedge SYS_CLK) begin
    if (RST) begin
      wp_q <= 1'b0;
      wp_bank_q <= 3'h0;
      wp_col_q <= {COL_W{1'b0}};
      wr_act_q <= 1'b0;
      wr_cnt_q <= 3'h0;
      wr_bank_q <= 3'h0;
      wr_col_q <= {COL_W{1'b0}};
    end else begin
      if (wr_start) begin
        wp_q <= 1'b0;
        wr_act_q <= 1'b1;
        wr_cnt_q <= 3'h1;
        wr_bank_q <= wp_bank_q;
        wr_col_q <= wp_col_q;
      end else if (dqs_edge && wr_act_q) begin
        wr_cnt_q <= wr_cnt_q + 3'h1;
        if (wr_cnt_q == last_beat) begin
          wr_act_q <= 1'b0;
        end
      end
      if (ck_fall && pv_wr[i_warm]) begin
        wp_q <= 1'b1;
        wp_bank_q <= p_bank[i_warm];
        wp_col_q <= p_col[i_warm];
      end
    end
  end

  dca_mem #(
    .AW(AW),
    .LANES(2)
  ) u_mem (
    .clk(SYS_CLK),
    .wr_en(wr_take),
    .wr_addr(wr_addr),
    .wr_data(dq_s),
    .wr_be(~dm_s),
    .rd_en(rd_issue),
    .rd_addr(rd_addr),
    .rd_data(mem_rdata)
  );

  // AHB-Lite slave, zero wait states
  wire ap = HSEL & HTRANS[`DCA_HTRANS_ACT] & HREADY;
  reg dwr_q;
  reg [7:0] wa_q;
  wire [7:0] pre_mask = addr_s[`DCA_AP_BIT] ? 8'hFF : bank_hot(ba_s);
  wire col_bad = (cmd_rd | cmd_wr) & ~|(bank_q & bank_hot(ba_s));
  wire sw_bank = dwr_q & (wa_q == `DCA_OFF_BANK);
  wire sw_clr = dwr_q & (wa_q == `DCA_OFF_STAT) & HWDATA[`DCA_ST_ERR];
  wire [7:0] bank_d = (sw_bank ? HWDATA[7:0] : bank_q) &
    ~(cmd_pre ? pre_mask : 8'h00);

  function [31:0] reg_read;
    input [7:0] off;
    begin
      reg_read = 32'h00000000;
      case (off)
        `DCA_OFF_MODE: reg_read = mode_q;
        `DCA_OFF_EXT: reg_read = ext_q;
        `DCA_OFF_BANK: reg_read = {24'h000000, bank_q};
        `DCA_OFF_STAT: begin
          reg_read[7:0] = bank_q;
          reg_read[`DCA_ST_RDACT] = rd_act_q;
          reg_read[`DCA_ST_WRACT] = wr_act_q;
          reg_read[`DCA_ST_ERR] = err_q;
        end
        default: reg_read = 32'h00000000;
      endcase
    end
  endfunction

  always @(posedge SYS_CLK) begin
    if (RST) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      dwr_q <= 1'b0;
      wa_q <= 8'h00;
      mode_q <= `DCA_MODE_RST;
      ext_q <= `DCA_EXT_RST;
      bank_q <= `DCA_BANK_RST;
      err_q <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      dwr_q <= ap & HWRITE;
      if (ap) begin
        wa_q <= HADDR[7:0];
      end
      if (ap && !HWRITE) begin
        HRDATA <= reg_read(HADDR[7:0]);
      end
      if (dwr_q && wa_q == `DCA_OFF_MODE) begin
        mode_q <= HWDATA;
      end
      if (dwr_q && wa_q == `DCA_OFF_EXT) begin
        ext_q <= HWDATA;
      end
      bank_q <= bank_d;
      // New error wins over a clear in the same cycle
      err_q <= col_bad | (err_q & ~sw_clr);
    end
  end
endmodule // dca_column_access

// File: dca_consts.vh
// Constants for the DDR2 column access and precharge block.
// Assumes inclusion by bare name from the design files.
`ifndef DCA_CONSTS_VH
`define DCA_CONSTS_VH

`define DCA_OFF_MODE 8'h00
`define DCA_OFF_EXT 8'h04
`define DCA_OFF_BANK 8'h08
`define DCA_OFF_STAT 8'h0C

`define DCA_MODE_RST 32'h00000032
`define DCA_EXT_RST 32'h00000000
`define DCA_BANK_RST 8'h00

`define DCA_BL_MSB 2
`define DCA_BL_LSB 0
`define DCA_BT_BIT 3
`define DCA_CL_MSB 6
`define DCA_CL_LSB 4
`define DCA_AL_MSB 5
`define DCA_AL_LSB 3
`define DCA_BL8_CODE 3'h3

`define DCA_ST_RDACT 8
`define DCA_ST_WRACT 9
`define DCA_ST_ERR 10

`define DCA_AP_BIT 10
`define DCA_HTRANS_ACT 1

`define DCA_RD_TAP 4'h1
`define DCA_PRE_TAP 4'h2
`define DCA_WARM_TAP 4'h2
`define DCA_LAST_BL4 3'h3
`define DCA_LAST_BL8 3'h7

`endif

// File: dca_mem.v
// Burst data store: one write port with byte enables, one read port.
// Assumes a single clock; read data appear one edge after rd_en.
`timescale 1ns/1ps
module dca_mem #(
  parameter AW = 13,
  parameter LANES = 2
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [LANES*8-1:0] wr_data,
  input wire [LANES-1:0] wr_be,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output wire [LANES*8-1:0] rd_data
);
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      // One array per lane so no array has two writing processes
      reg [7:0] mem [0:(1<<AW)-1];
      reg [7:0] rd_q;
      always @(posedge clk) begin
        if (wr_en && wr_be[g]) begin
          mem[wr_addr] <= wr_data[g*8 +: 8];
        end
        if (rd_en) begin
          rd_q <= mem[rd_addr];
        end
      end
      assign rd_data[g*8 +: 8] = rd_q;
    end
  endgenerate
endmodule // dca_mem

// File: dca_chk.sv
// Checker for the read strobe, read data enables and the bus answer.
// Assumes the ports of dca_column_access; bound after the module.
`timescale 1ns/1ps
module dca_chk (
  input wire SYS_CLK,
  input wire RST,
  input wire HREADYOUT,
  input wire HRESP,
  input wire DQ_OE,
  input wire DQS_OE,
  input wire DQS_OUT
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // Preamble is one link clock, 16 system clocks; margin for sampling
  sequence pre_s;
    DQS_OE && !DQ_OE && !DQS_OUT;
  endsequence
  sequence beat0_s;
    DQ_OE && DQS_OUT;
  endsequence
  chk_ready_high: assert property (HREADYOUT)
    else $error("ready low");
  chk_resp_okay: assert property (!HRESP)
    else $error("response not okay");
  chk_dq_dqs: assert property (DQ_OE |-> DQS_OE)
    else $error("data driven without strobe");
  chk_pre_len: assert property ($rose(DQS_OE) |-> pre_s[*8] ##[6:10] beat0_s)
    else $error("preamble length wrong");
  chk_first_rise: assert property ($rose(DQ_OE) |-> DQS_OUT)
    else $error("first beat not on rising strobe");
  chk_beat_half: assert property (DQ_OE && $rose(DQS_OUT) |-> DQS_OUT[*6] ##[1:4] !DQS_OUT)
    else $error("strobe high not half a clock");
  chk_last_low: assert property ($fell(DQ_OE) |-> !$past(DQS_OUT))
    else $error("burst did not end low");
  chk_oe_pair: assert property ($fell(DQS_OE) |-> $fell(DQ_OE))
    else $error("strobe released alone");
endmodule // dca_chk
bind dca_column_access dca_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DQ_OE(DQ_OE), .DQS_OE(DQS_OE),
  .DQS_OUT(DQS_OUT));

// File: dca_ctl_model.sv
// Controller model: link clock, commands, write strobe and write data.
// Assumes the bench sets wl and bl to match the programmed latency.
`timescale 1ns/1ps
module dca_ctl_model (
  output logic CK,
  output logic CS_N,
  output logic RAS_N,
  output logic CAS_N,
  output logic WE_N,
  output logic [13:0] ADDR,
  output logic [2:0] BA,
  output logic [1:0] DM,
  output logic [15:0] DQ_IN,
  output logic DQS_IN
);
  int wl = 2;
  int bl = 4;
  int act = 0;
  time tc = 0;
  initial begin
    {CS_N, RAS_N, CAS_N, WE_N, DQS_IN} = 5'h1F;
    {ADDR, BA, DM, DQ_IN} = 35'h0;
    CK = 1'b0;
    #2;
    forever #40 CK = ~CK;
  end
  // Data change a quarter clock before each strobe edge
  task automatic drv(input logic [15:0] d, input logic [1:0] mk,
      input bit rel);
    repeat (wl - 1) @(posedge CK);
    if (act == 0) DQS_IN <= 1'b0;
    act++;
    #40;
    for (int i = 0; i < bl; i++) begin
      #20 DQ_IN <= d + i[15:0];
      DM <= (i == 1) ? mk : 2'h0;
      #20 DQS_IN <= ~i[0];
    end
    act--;
    // Released lines show junk and a stray strobe edge
    if (rel) begin
      #20 DQ_IN <= ~DQ_IN;
      DQS_IN <= ~DQS_IN;
      DM <= ~DM;
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [2:0] b,
      input logic [13:0] a, input int gap, input logic [15:0] d,
      input logic [1:0] mk, input bit rel);
    @(negedge CK);
    {CS_N, RAS_N, CAS_N, WE_N} <= {1'b0, op};
    BA <= b;
    ADDR <= a;
    @(posedge CK);
    tc = $time;
    if (op == 3'b100) fork drv(d, mk, rel); join_none
    @(negedge CK);
    {CS_N, RAS_N, CAS_N, WE_N} <= 4'hF;
    BA <= ~b;
    ADDR <= ~a;
    repeat (gap - 1) @(posedge CK);
  endtask
endmodule // dca_ctl_model

// File: tb_ddr2_column_access_precharge.sv
// Self-checking bench for the column access block.
// Assumes the controller model drives the link pins.
`timescale 1ns/1ps
module tb_ddr2_column_access_precharge;
  localparam logic [2:0] RD = 3'b101;
  localparam logic [2:0] WR = 3'b100;
  localparam logic [2:0] PR = 3'b010;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  wire [31:0] HRDATA;
  wire HREADYOUT, HRESP, CK, CS_N, RAS_N, CAS_N, WE_N, DQS_IN;
  wire DQ_OE, DQS_OUT, DQS_OE;
  wire [13:0] ADDR;
  wire [2:0] BA;
  wire [1:0] DM;
  wire [15:0] DQ_IN, DQ_OUT;
  int error_cnt = 0;
  int n_tests = 0;
  logic [15:0] eq[$];
  logic [31:0] rv;
  always #2.5 SYS_CLK = ~SYS_CLK;
  dca_column_access dut (.SYS_CLK(SYS_CLK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CK(CK), .CS_N(CS_N),
    .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .ADDR(ADDR), .BA(BA),
    .DM(DM), .DQ_IN(DQ_IN), .DQS_IN(DQS_IN), .DQ_OUT(DQ_OUT),
    .DQ_OE(DQ_OE), .DQS_OUT(DQS_OUT), .DQS_OE(DQS_OE));
  dca_ctl_model ctl (.CK(CK), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
    .WE_N(WE_N), .ADDR(ADDR), .BA(BA), .DM(DM), .DQ_IN(DQ_IN),
    .DQS_IN(DQS_IN));
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    rv = HRDATA;
  endtask
  // Samples each beat mid-way; strobe must alternate from high
  task automatic get_rd(input int rl, input time t0);
    int t;
    t = 0;
    while (DQ_OE !== 1'b1 && t < 300) begin
      @(negedge SYS_CLK);
      t++;
    end
    chk("latency", rl, ($time - t0) / 80);
    repeat (3) @(negedge SYS_CLK);
    foreach (eq[k]) begin
      chk("dq", eq[k], DQ_OUT);
      chk("dqs", !k[0], DQS_OUT);
      repeat (8) @(negedge SYS_CLK);
    end
    eq = {};
  endtask
  task automatic t_regs();
    logic [7:0] a [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] e [5] = '{32'h32, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, a[i], 32'h0);
      chk("reg", e[i], rv);
    end
  endtask
  task automatic t_wr_rd();
    time t0;
    ahb(1'b1, 8'h08, 32'hFF);
    ctl.cmd(WR, 3'h2, 14'h000, 2, 16'h1055, 2'h0, 1'b0);
    ctl.cmd(WR, 3'h2, 14'h004, 4, 16'h2000, 2'h0, 1'b1);
    ctl.cmd(WR, 3'h2, 14'h000, 6, 16'h3000, 2'h1, 1'b1);
    ctl.cmd(RD, 3'h2, 14'h000, 2, 16'h0, 2'h0, 1'b0);
    t0 = ctl.tc;
    eq = '{16'h3000, 16'h3056, 16'h3002, 16'h3003,
      16'h2000, 16'h2001, 16'h2002, 16'h2003};
    fork
      ctl.cmd(RD, 3'h2, 14'h004, 4, 16'h0, 2'h0, 1'b0);
      get_rd(3, t0);
    join
  endtask
  task automatic t_order();
    ahb(1'b1, 8'h00, 32'h3A);
    ahb(1'b1, 8'h04, 32'h08);
    ctl.cmd(RD, 3'h2, 14'h001, 4, 16'h0, 2'h0, 1'b0);
    eq = '{16'h3056, 16'h3000, 16'h3003, 16'h3002};
    get_rd(4, ctl.tc);
  endtask
  task automatic t_bl8();
    time t0;
    ahb(1'b1, 8'h00, 32'h33);
    ahb(1'b1, 8'h04, 32'h00);
    ctl.bl = 8;
    ctl.cmd(WR, 3'h3, 14'h000, 8, 16'h5000, 2'h0, 1'b1);
    ctl.cmd(RD, 3'h3, 14'h000, 2, 16'h0, 2'h0, 1'b0);
    t0 = ctl.tc;
    eq = '{16'h5000, 16'h5001, 16'h5002, 16'h5003, 16'h3000, 16'h3056,
      16'h3002, 16'h3003, 16'h2000, 16'h2001, 16'h2002, 16'h2003};
    fork
      ctl.cmd(RD, 3'h2, 14'h000, 4, 16'h0, 2'h0, 1'b0);
      get_rd(3, t0);
    join
  endtask
  task automatic t_pre();
    ctl.cmd(PR, 3'h2, 14'h0000, 2, 16'h0, 2'h0, 1'b0);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("status", 32'hFB, rv);
    ctl.cmd(PR, 3'h5, 14'h0000, 2, 16'h0, 2'h0, 1'b0);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("status", 32'hDB, rv);
    ctl.cmd(PR, 3'h2, 14'h0400, 2, 16'h0, 2'h0, 1'b0);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("status", 32'h00, rv);
    ctl.cmd(RD, 3'h1, 14'h000, 4, 16'h0, 2'h0, 1'b0);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("closed", 32'h400, rv & 32'h400);
    ahb(1'b1, 8'h0C, 32'h400);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("cleared", 32'h0, rv & 32'h400);
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_regs();
    t_wr_rd();
    t_order();
    t_bl8();
    t_pre();
    stop_test();
  end
  // Whole run is some 60 link clocks; this is ample
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule // tb_ddr2_column_access_precharge
